// file: cpu_regs_cfg.svh
/*
  Constants of the CPU register and flag file: bus offsets, reset values,
  status-word field positions and bus response codes.
  Assumes inclusion by bare name from the design file; holds definitions only.
*/
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH

// ----------------------------------------
// register offsets on the control bus
// ----------------------------------------
`define OFS_PC 8'h00
`define OFS_ACC 8'h04
`define OFS_TMP 8'h08
`define OFS_IX 8'h0c
`define OFS_EP 8'h10
`define OFS_SP 8'h14
`define OFS_PS 8'h18

// ----------------------------------------
// reset values
// ----------------------------------------
`define PC_RESET 16'hfffd
`define PS_RESET 16'h0030
`define WORD_RESET 16'h0000

// ----------------------------------------
// status word fields
// ----------------------------------------
`define PS_RP_LSB 8
`define FLAG_H 7
`define FLAG_I 6
`define IL_HI 5
`define IL_LO 4
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: cpu_regs_pkg.sv
/*
  Types of the CPU register and flag file.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cpu_regs_pkg;

	// ----------------------------------------
	// operations and selectors
	// ----------------------------------------
	typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR} alu_op_t;
	typedef enum logic [2:0] {SEL_PC, SEL_ACC, SEL_TMP, SEL_IX, SEL_EP, SEL_SP, SEL_PS,
		SEL_NONE} reg_sel_t;
	typedef enum logic [1:0] {REGION_IO, REGION_DATA, REGION_PROGRAM} region_t;

	// ----------------------------------------
	// result of one arithmetic step
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] value;
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} alu_out_t;

	// ----------------------------------------
	// whole state of the register file
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] acc;
		logic [15:0] tmp;
		logic [15:0] ix;
		logic [15:0] ep;
		logic [15:0] sp;
		logic [15:0] ps;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
	} regs_state_t;

endpackage

// file: cpu_register_and_flag_file.sv
/*
  Dedicated register set, status word and condition-code logic of an 8-bit
  CPU core, with memory-space decode and register-bank address forming.
  Assumes the instruction sequencer drives the core-side strobes on ref_clk,
  and software reaches the registers through an AXI4-Lite slave port.
*/
`include "cpu_regs_cfg.svh"

module cpu_register_and_flag_file
	import cpu_regs_pkg::*;
#(
	parameter logic [15:0] IO_TOP = 16'h007f, // last I/O address
	parameter logic [15:0] DATA_TOP = 16'h047f, // last data address
	parameter logic [15:0] VECTOR_BASE = 16'hffc0, // lowest vector-table address
	parameter logic [15:0] GPR_BASE = 16'h0100, // first general register byte
	parameter int BANK_COUNT = 16 // usable register banks
)
(
	input wire logic ref_clk, // core clock
	input wire logic rst_b, // asynchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic pc_step, // advance to next instruction byte
	input wire logic core_wr_en, // core loads one register
	input wire reg_sel_t core_wr_sel, // register the core loads
	input wire logic [15:0] core_wr_data, // value the core loads
	input wire logic alu_go, // run one arithmetic step
	input wire alu_op_t alu_op, // arithmetic operation
	input wire logic alu_wide, // 16-bit operation when high
	input wire logic irq_req, // interrupt request present
	input wire logic [1:0] irq_level, // level code of the request
	output logic irq_accept, // request admitted
	input wire logic [2:0] gpr_num, // general register number
	output logic [15:0] gpr_addr, // its byte address
	input wire logic [15:0] query_addr, // address to classify
	output region_t query_region, // area of that address
	output logic query_vector, // address lies in the vector tables
	output logic [15:0] program_counter, // program counter
	output logic [15:0] accumulator, // accumulator
	output logic [15:0] temp_operand_reg, // temporary operand
	output logic [15:0] index_offset_reg, // index register
	output logic [15:0] auxiliary_pointer, // auxiliary pointer
	output logic [15:0] stack_top_pointer, // stack pointer
	output logic [15:0] processor_status_word // status word
);

	localparam int BANK_W = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1;

	regs_state_t s_reg;
	regs_state_t s_next;
	reg_sel_t w_sel;
	reg_sel_t r_sel;
	alu_out_t alu_res;
	logic [15:0] wr_word;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// word-aligned decode; low address bits ignored
	function automatic reg_sel_t decode(input logic [7:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		unique case ({addr[7:2], 2'b00})
			`OFS_PC: sel = SEL_PC;
			`OFS_ACC: sel = SEL_ACC;
			`OFS_TMP: sel = SEL_TMP;
			`OFS_IX: sel = SEL_IX;
			`OFS_EP: sel = SEL_EP;
			`OFS_SP: sel = SEL_SP;
			`OFS_PS: sel = SEL_PS;
			default: sel = SEL_NONE;
		endcase
		return sel;
	endfunction

	// load one dedicated register in a state copy
	function automatic regs_state_t put(input regs_state_t st, input reg_sel_t sel,
		input logic [15:0] v);
		regs_state_t o;
		o = st;
		unique case (sel)
			SEL_PC: o.pc = v;
			SEL_ACC: o.acc = v;
			SEL_TMP: o.tmp = v;
			SEL_IX: o.ix = v;
			SEL_EP: o.ep = v;
			SEL_SP: o.sp = v;
			SEL_PS: o.ps = v;
			default: o = st;
		endcase
		return o;
	endfunction

	// read one dedicated register
	function automatic logic [15:0] get(input regs_state_t st, input reg_sel_t sel);
		logic [15:0] v;
		v = 16'h0000;
		unique case (sel)
			SEL_PC: v = st.pc;
			SEL_ACC: v = st.acc;
			SEL_TMP: v = st.tmp;
			SEL_IX: v = st.ix;
			SEL_EP: v = st.ep;
			SEL_SP: v = st.sp;
			SEL_PS: v = st.ps;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// arithmetic on accumulator and temporary operand, with flags
	function automatic alu_out_t alu(input alu_op_t op, input logic wide,
		input logic [15:0] a, input logic [15:0] t);
		alu_out_t o;
		logic [15:0] aw;
		logic [15:0] tw;
		logic [16:0] r17;
		logic [4:0] h5;
		logic sa;
		logic st;
		logic sr;
		aw = wide ? a : {8'h00, a[7:0]}; // byte work sees lower bytes only
		tw = wide ? t : {8'h00, t[7:0]};
		r17 = 17'h00000;
		h5 = 5'h00;
		o = '0;
		unique case (op)
			ALU_ADD:
			begin
				r17 = {1'b0, aw} + {1'b0, tw};
				h5 = {1'b0, aw[3:0]} + {1'b0, tw[3:0]};
				o.c = wide ? r17[16] : r17[8];
			end
			ALU_SUB:
			begin
				r17 = {1'b0, aw} - {1'b0, tw};
				h5 = {1'b0, aw[3:0]} - {1'b0, tw[3:0]};
				o.c = wide ? r17[16] : r17[8];
			end
			ALU_SHL:
			begin
				r17 = {aw, 1'b0};
				o.c = wide ? aw[15] : aw[7];
			end
			ALU_SHR:
			begin
				r17 = {2'b00, aw[15:1]};
				o.c = aw[0];
			end
		endcase
		o.h = h5[4];
		sa = wide ? aw[15] : aw[7];
		st = wide ? tw[15] : tw[7];
		sr = wide ? r17[15] : r17[7];
		o.n = sr;
		o.z = wide ? (r17[15:0] == 16'h0000) : (r17[7:0] == 8'h00);
		if (op == ALU_ADD)
		begin
			o.v = (sa == st) && (sr != sa);
		end
		else if (op == ALU_SUB)
		begin
			o.v = (sa != st) && (sr != sa);
		end
		else
		begin
			o.v = 1'b0;
		end
		// byte results keep the accumulator's upper byte
		o.value = wide ? r17[15:0] : {a[15:8], r17[7:0]};
		return o;
	endfunction

	// area of a 16-bit address
	function automatic region_t region(input logic [15:0] addr);
		region_t r;
		if (addr <= IO_TOP)
		begin
			r = REGION_IO;
		end
		else if (addr <= DATA_TOP)
		begin
			r = REGION_DATA;
		end
		else
		begin
			r = REGION_PROGRAM;
		end
		return r;
	endfunction

	// merge a 16-bit word under byte strobes
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		w_sel = decode(s_reg.aw_addr);
		r_sel = decode(s_axi_araddr);
		alu_res = alu(alu_op, alu_wide, s_reg.acc, s_reg.tmp);
		wr_word = merge(get(s_reg, w_sel), s_reg.w_data, s_reg.w_strb);

		// sequencer effects; a later load in the same cycle wins
		if (pc_step)
		begin
			s_next.pc = s_reg.pc + 16'h0001;
		end
		if (alu_go)
		begin
			s_next.acc = alu_res.value;
			s_next.ps[`FLAG_H] = alu_res.h;
			s_next.ps[`FLAG_N] = alu_res.n;
			s_next.ps[`FLAG_Z] = alu_res.z;
			s_next.ps[`FLAG_V] = alu_res.v;
			s_next.ps[`FLAG_C] = alu_res.c;
		end
		if (core_wr_en)
		begin
			s_next = put(s_next, core_wr_sel, core_wr_data);
		end

		// write channel: address and data taken in either order
		if (s_axi_awvalid && !s_reg.aw_held)
		begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_held)
		begin
			s_next.w_held = 1'b1;
			s_next.w_data = s_axi_wdata[15:0];
			s_next.w_strb = s_axi_wstrb[1:0]; // upper lanes have no storage
		end
		if (s_reg.bvalid && s_axi_bready)
		begin
			s_next.bvalid = 1'b0;
		end
		// software write lands last, so it overrides the sequencer this cycle
		if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
		begin
			s_next = put(s_next, w_sel, wr_word);
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = (w_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end

		// read channel: one read in flight
		if (s_reg.rvalid && s_axi_rready)
		begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_reg.rvalid)
		begin
			s_next.rvalid = 1'b1;
			s_next.rdata = get(s_reg, r_sel);
			s_next.rresp = (r_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// registers the hardware leaves undefined are cleared for determinism
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg <= '0;
			s_reg.pc <= `PC_RESET;
			s_reg.acc <= `WORD_RESET;
			s_reg.tmp <= `WORD_RESET;
			s_reg.ix <= `WORD_RESET;
			s_reg.ep <= `WORD_RESET;
			s_reg.sp <= `WORD_RESET;
			s_reg.ps <= `PS_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// ready terms are combinational from the held flags and rvalid
	assign s_axi_awready = !s_reg.aw_held;
	assign s_axi_wready = !s_reg.w_held;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rdata = {16'h0000, s_reg.rdata};

	assign program_counter = s_reg.pc;
	assign accumulator = s_reg.acc;
	assign temp_operand_reg = s_reg.tmp;
	assign index_offset_reg = s_reg.ix;
	assign auxiliary_pointer = s_reg.ep;
	assign stack_top_pointer = s_reg.sp;
	assign processor_status_word = s_reg.ps;

	// level field 00 admits nothing, since no code is below it
	assign irq_accept = irq_req && s_reg.ps[`FLAG_I]
		&& (irq_level < s_reg.ps[`IL_HI:`IL_LO]);

	// bank pointer low bits beside the register number, offset into data
	assign gpr_addr = GPR_BASE
		+ 16'({s_reg.ps[`PS_RP_LSB +: BANK_W], gpr_num});

	assign query_region = region(query_addr);
	assign query_vector = (query_addr >= VECTOR_BASE);

endmodule

// file: regs_sva.sv
/*
  Checker for the cpu register file: reset values, flags, interrupt gate, bank addressing.
  Assumes it is bound to cpu_register_and_flag_file, one clock domain.
*/
module regs_sva
	import cpu_regs_pkg::*;
#(
	parameter logic [15:0] GPR_BASE = 16'h0100, // first general register byte
	parameter int BANK_COUNT = 16 // usable banks
)
(
	input wire logic ref_clk, // core clock
	input wire logic rst_b, // reset, active low
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic pc_step, // pc advance
	input wire logic core_wr_en, // core load
	input wire logic alu_go, // arithmetic step
	input wire alu_op_t alu_op, // operation
	input wire logic alu_wide, // wide operation
	input wire logic irq_req, // request present
	input wire logic [1:0] irq_level, // request level
	input wire logic irq_accept, // request admitted
	input wire logic [2:0] gpr_num, // register number
	input wire logic [15:0] gpr_addr, // its address
	input wire logic [15:0] program_counter, // pc
	input wire logic [15:0] accumulator, // acc
	input wire logic [15:0] processor_status_word // status word
);
	localparam int BW = $clog2(BANK_COUNT);
	logic quiet;
	logic byte_op;
	logic [15:0] ps;
	// ----
	// helpers
	// ----
	// a bus write or core load may override the step, so those cycles are left out
	assign quiet = s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid && !core_wr_en;
	assign byte_op = quiet && alu_go && !alu_wide;
	assign ps = processor_status_word;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	chk_pc_reset: assert property ($rose(rst_b) |-> program_counter == 16'hfffd)
		else $error("pc not at reset value");
	chk_ps_reset: assert property ($rose(rst_b) |-> ps[6:4] == 3'b011)
		else $error("status word not at reset value");
	chk_irq_gate: assert property (irq_accept == (irq_req && ps[6] && irq_level < ps[5:4]))
		else $error("interrupt gate wrong");
	chk_pc_step: assert property (quiet && pc_step |=> program_counter == $past(program_counter) + 16'h0001)
		else $error("pc did not advance");
	chk_acc_upper: assert property (byte_op |=> $stable(accumulator[15:8]))
		else $error("byte op changed upper byte");
	chk_zero_flag: assert property (byte_op |=> ps[2] == (accumulator[7:0] == 8'h00))
		else $error("zero flag wrong");
	chk_neg_flag: assert property (byte_op |=> ps[3] == accumulator[7])
		else $error("negative flag wrong");
	chk_shr_carry: assert property (byte_op && alu_op == ALU_SHR |=> ps[0] == $past(accumulator[0]))
		else $error("shift carry wrong");
	chk_bank_addr: assert property (gpr_addr == 16'(GPR_BASE + {ps[8 +: BW], gpr_num}))
		else $error("bank address wrong");
endmodule

bind cpu_register_and_flag_file regs_sva #(.GPR_BASE(GPR_BASE), .BANK_COUNT(BANK_COUNT)) u_sva (
	.ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .pc_step,
	.core_wr_en, .alu_go, .alu_op, .alu_wide, .irq_req, .irq_level, .irq_accept, .gpr_num,
	.gpr_addr, .program_counter, .accumulator, .processor_status_word);

// file: tb.sv
/*
  Self-checking bench of the cpu register file over AXI4-Lite and core strobes.
  Assumes the package, the design and the bound checker are compiled first.
*/
module tb import cpu_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'h0, rst_b = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic pc_step = 1'h0, core_wr_en = 1'h0, alu_go = 1'h0, alu_wide = 1'h0, irq_req = 1'h0;
	reg_sel_t core_wr_sel = SEL_NONE;
	alu_op_t alu_op = ALU_ADD;
	logic [15:0] core_wr_data = 16'h0, query_addr = 16'h0;
	logic [1:0] irq_level = 2'h0;
	logic [2:0] gpr_num = 3'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic irq_accept, query_vector;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	region_t query_region;
	logic [15:0] gpr_addr, program_counter, accumulator, temp_operand_reg, index_offset_reg;
	logic [15:0] auxiliary_pointer, stack_top_pointer, processor_status_word;
	wire [15:0] seen [7];
	logic [15:0] qa [6] = '{16'h007f, 16'h0080, 16'h047f, 16'h0480, 16'hffbf, 16'hffc0};
	logic [2:0] qe [6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h6};
	int mismatches = 0, checks_done = 0, cycles = 0;

	assign seen = '{program_counter, accumulator, temp_operand_reg, index_offset_reg,
		auxiliary_pointer, stack_top_pointer, processor_status_word};

	cpu_register_and_flag_file DUT (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_step, .core_wr_en,
		.core_wr_sel, .core_wr_data, .alu_go, .alu_op, .alu_wide, .irq_req, .irq_level,
		.irq_accept, .gpr_num, .gpr_addr, .query_addr, .query_region, .query_vector,
		.program_counter, .accumulator, .temp_operand_reg, .index_offset_reg,
		.auxiliary_pointer, .stack_top_pointer, .processor_status_word);

	// ----
	// clock and hang guard
	// ----
	always #20 ref_clk = ~ref_clk;
	// the whole run needs about two hundred cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----
	// bus and core drivers
	// ----
	// address and data are offered together; each drops on its own ready
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic pa = 1'h1;
		logic pw = 1'h1;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (pa || pw)
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				pa = 1'h0;
			if (s_axi_wready)
				pw = 1'h0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do @(posedge ref_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h1;
		@(posedge ref_clk);
		s_axi_bready <= 1'h0;
		r = s_axi_bresp;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h1;
		@(posedge ref_clk);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic core_ld(input reg_sel_t s, input logic [15:0] d);
		@(posedge ref_clk);
		core_wr_en <= 1'h1;
		core_wr_sel <= s;
		core_wr_data <= d;
		@(posedge ref_clk);
		core_wr_en <= 1'h0;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset_vals();
		chk("pc reset", program_counter, 16'hfffd);
		chk("ps reset", processor_status_word, 16'h0030);
	endtask

	task automatic t_bus_regs();
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] v;
		for (int i = 0; i < 7; i++)
		begin
			v = 16'h9c5a ^ 16'(16'h1111 * i);
			bus_wr(8'(4 * i), v, 4'hf, r);
			chk("write okay", r, 2'h0);
			bus_rd(8'(4 * i), d, r);
			chk("read okay", r, 2'h0);
			chk("read back", d, {16'h0, v});
			chk("register out", seen[i], v);
		end
		bus_wr(8'h00, 16'h0000, 4'h1, r);
		chk("lane write", program_counter, 16'h9c00);
		bus_wr(8'h1c, 16'h1234, 4'hf, r);
		chk("unmapped write", r, 2'h2);
		bus_rd(8'h1c, d, r);
		chk("unmapped read", r, 2'h2);
		chk("unmapped data", d, 32'h0);
	endtask

	task automatic t_pc_step();
		core_ld(SEL_PC, 16'hfffe);
		@(posedge ref_clk);
		pc_step <= 1'h1;
		repeat (3) @(posedge ref_clk);
		pc_step <= 1'h0;
		@(negedge ref_clk);
		chk("pc wrap", program_counter, 16'h0001);
	endtask

	// flags are packed as h, n, z, v, c
	task automatic run_alu(input alu_op_t op, input logic w, input logic [15:0] a, t, res,
		input logic [4:0] fl);
		core_ld(SEL_ACC, a);
		core_ld(SEL_TMP, t);
		@(posedge ref_clk);
		alu_go <= 1'h1;
		alu_op <= op;
		alu_wide <= w;
		@(posedge ref_clk);
		alu_go <= 1'h0;
		@(negedge ref_clk);
		chk("alu result", accumulator, res);
		chk("flags", {processor_status_word[7], processor_status_word[3:0]}, fl);
	endtask

	task automatic t_alu();
		run_alu(ALU_ADD, 1'h0, 16'ha50f, 16'h3c01, 16'ha510, 5'h10);
		run_alu(ALU_ADD, 1'h0, 16'ha57f, 16'h3c01, 16'ha580, 5'h1a);
		run_alu(ALU_ADD, 1'h0, 16'ha5ff, 16'h3c01, 16'ha500, 5'h15);
		run_alu(ALU_ADD, 1'h0, 16'ha510, 16'h3c01, 16'ha511, 5'h00);
		run_alu(ALU_SUB, 1'h0, 16'ha500, 16'h3c01, 16'ha5ff, 5'h19);
		run_alu(ALU_SUB, 1'h0, 16'ha580, 16'h3c01, 16'ha57f, 5'h12);
		run_alu(ALU_SHL, 1'h0, 16'ha581, 16'h3c01, 16'ha502, 5'h01);
		run_alu(ALU_SHR, 1'h0, 16'ha501, 16'h3c01, 16'ha500, 5'h05);
		run_alu(ALU_ADD, 1'h1, 16'hffff, 16'h0001, 16'h0000, 5'h15);
		run_alu(ALU_ADD, 1'h1, 16'h7fff, 16'h0001, 16'h8000, 5'h1a);
	endtask

	task automatic t_irq();
		for (int il = 0; il < 4; il++)
		begin
			core_ld(SEL_PS, 16'(16'h0040 | (il << 4)));
			for (int lv = 0; lv < 4; lv++)
			begin
				@(posedge ref_clk);
				irq_req <= 1'h1;
				irq_level <= 2'(lv);
				@(negedge ref_clk);
				chk("irq level", irq_accept, lv < il);
			end
		end
		// level 0 would pass the level gate, so only the enable flag can block it
		core_ld(SEL_PS, 16'h0030);
		irq_level <= 2'h0;
		@(negedge ref_clk);
		chk("irq disabled", irq_accept, 1'h0);
	endtask

	task automatic t_map();
		core_ld(SEL_PS, 16'h0b00);
		@(posedge ref_clk);
		gpr_num <= 3'h5;
		@(negedge ref_clk);
		chk("bank address", gpr_addr, 16'h015d);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge ref_clk);
			query_addr <= qa[i];
			@(negedge ref_clk);
			chk("region", {query_vector, query_region}, qe[i]);
		end
	endtask

	// reset in mid-run with the pc strobe held: stepping resumes from the reset value
	task automatic t_rereset();
		@(posedge ref_clk);
		rst_b <= 1'h0;
		pc_step <= 1'h1;
		@(negedge ref_clk);
		t_reset_vals();
		@(posedge ref_clk);
		rst_b <= 1'h1;
		@(posedge ref_clk);
		pc_step <= 1'h0;
		@(negedge ref_clk);
		chk("pc after reset", program_counter, 16'hfffe);
	endtask

	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'h1;
		@(negedge ref_clk);
		t_reset_vals();
		t_bus_regs();
		t_pc_step();
		t_alu();
		t_irq();
		t_map();
		t_rereset();
		end_of_test();
	end
endmodule
